//--- core/gdcr_top.sv
// configuration store and read-back replies of the gate driver
// assumes the framer gives one-cycle write and query strobes on clock
`timescale 1ns/1ps
module gdcr_top
  import gdcr_pkg::*;
#(
  parameter logic [3:0] HW_REV = HW_REV_DEFAULT
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic drive_enable,
  input wire logic cfg_wr,
  input wire logic [7:0] cfg_wdata,
  input wire logic tim_wr,
  input wire logic [7:0] tim_wdata,
  input wire logic [1:0] query,
  input wire logic query_ok,
  output logic [7:0] cfg_rdata,
  output logic reply_valid,
  output gdcr_reply_t reply,
  output gdcr_mode_t mode,
  output logic amp_powered,
  output gdcr_settings_t settings
);

  // ----------------------------------------------------------------
  // drive-enable pin synchroniser
  // ----------------------------------------------------------------
  logic [2:0] de_sync_r;
  logic de_level_r;

  always_ff @(posedge clock) begin
    if (!rstn) begin
      de_sync_r <= 3'h0;
    end else begin
      de_sync_r <= {de_sync_r[1:0], drive_enable};
    end
  end

  // a change counts only once the two later stages agree
  always_ff @(posedge clock) begin
    if (!rstn) begin
      de_level_r <= 1'b0;
    end else if (de_sync_r[1] == de_sync_r[2]) begin
      de_level_r <= de_sync_r[2];
    end
  end

  // ----------------------------------------------------------------
  // configuration register
  // ----------------------------------------------------------------
  logic [7:0] cfg_r;
  logic [7:0] cfg_nxt;
  gdcr_mode_t mode_r;

  always_comb begin
    cfg_nxt = (cfg_r & ~CFG_WMASK) | (cfg_wdata & CFG_WMASK);
    // sleep selection is frozen outside standby so a stray write cannot arm sleep
    if (mode_r != GDCR_STANDBY) begin
      cfg_nxt[CFG_SLEEP_SEL_BIT] = cfg_r[CFG_SLEEP_SEL_BIT];
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      cfg_r <= CFG_RESET;
    end else if (cfg_wr) begin
      cfg_r <= cfg_nxt;
    end
  end

  assign cfg_rdata = cfg_r;

  // ----------------------------------------------------------------
  // timing configuration
  // ----------------------------------------------------------------
  logic [2:0] dt_r;
  logic [1:0] bl_r;

  always_ff @(posedge clock) begin
    if (!rstn) begin
      dt_r <= DT_RESET;
      bl_r <= BL_RESET;
    end else if (tim_wr) begin
      dt_r <= tim_wdata[DT_LSB +: DT_W];
      bl_r <= tim_wdata[BL_LSB +: BL_W];
    end
  end

  // ----------------------------------------------------------------
  // power mode
  // ----------------------------------------------------------------
  gdcr_mode_t mode_nxt;

  // the stored selection alone decides where a low drive-enable leads
  function automatic gdcr_mode_t idle_mode(logic sleep_sel);
    return sleep_sel ? GDCR_SLEEP : GDCR_STANDBY;
  endfunction

  // debounce of the low level (1 ms) is left to the power sequencer
  always_comb begin
    mode_nxt = mode_r;
    unique case (mode_r)
      GDCR_ACTIVE: begin
        if (!de_level_r) begin
          mode_nxt = idle_mode(cfg_r[CFG_SLEEP_SEL_BIT]);
        end
      end
      GDCR_STANDBY: begin
        if (de_level_r) begin
          mode_nxt = GDCR_ACTIVE;
        end else begin
          // a selection written in standby takes effect at once
          mode_nxt = idle_mode(cfg_r[CFG_SLEEP_SEL_BIT]);
        end
      end
      GDCR_SLEEP: begin
        if (de_level_r) begin
          mode_nxt = GDCR_ACTIVE;
        end else begin
          mode_nxt = idle_mode(cfg_r[CFG_SLEEP_SEL_BIT]);
        end
      end
      default: begin
        // the unused code falls back to the low-power safe state
        mode_nxt = GDCR_STANDBY;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      mode_r <= GDCR_STANDBY;
    end else begin
      mode_r <= mode_nxt;
    end
  end

  assign mode = mode_r;

  // ----------------------------------------------------------------
  // settings out
  // ----------------------------------------------------------------
  logic amp_on_r;

  always_ff @(posedge clock) begin
    if (!rstn) begin
      amp_on_r <= 1'b1;
    end else begin
      amp_on_r <= !(mode_r == GDCR_STANDBY && cfg_r[CFG_AMP_PD_BIT]);
    end
  end

  assign amp_powered = amp_on_r;

  always_comb begin
    settings.amp_standby_off = cfg_r[CFG_AMP_PD_BIT];
    settings.fet_gate_lockout_disable = cfg_r[CFG_UVLO_DIS_BIT];
    settings.fet_short_detect_disable = cfg_r[CFG_SHORT_DIS_BIT];
    settings.oc_threshold = {cfg_r[CFG_OC_HI_BIT], cfg_r[CFG_OC_LO_BIT]};
    settings.dead_time_code = dt_r;
    settings.blank_code = bl_r;
  end

  // ----------------------------------------------------------------
  // query replies
  // ----------------------------------------------------------------
  gdcr_reply_t reply_r;
  gdcr_reply_t reply_nxt;
  logic reply_valid_r;

  // the head byte alone tells the host whether its query was taken
  function automatic gdcr_reply_t tim_reply(logic ok, logic [2:0] dt, logic [1:0] bl);
    gdcr_reply_t r;
    r.head = ok ? TIM_ACK : TIM_NAK;
    r.body = {3'h0, dt, bl};
    return r;
  endfunction

  function automatic gdcr_reply_t rev_reply(logic ok, logic [3:0] rev);
    gdcr_reply_t r;
    r.head = ok ? REV_ACK : REV_NAK;
    r.body = {4'h0, rev};
    return r;
  endfunction

  // codes 0 and 3 ask for nothing, so no reply is framed for them
  function automatic logic is_answered(logic [1:0] q);
    return (q == GDCR_Q_TIM) || (q == GDCR_Q_REV);
  endfunction

  // the last reply holds until the next answered query
  always_comb begin
    unique case (query)
      GDCR_Q_TIM: begin
        reply_nxt = tim_reply(query_ok, dt_r, bl_r);
      end
      GDCR_Q_REV: begin
        reply_nxt = rev_reply(query_ok, HW_REV);
      end
      default: begin
        reply_nxt = reply_r;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      reply_r <= '0;
    end else begin
      reply_r <= reply_nxt;
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      reply_valid_r <= 1'b0;
    end else begin
      reply_valid_r <= is_answered(query);
    end
  end

  assign reply = reply_r;
  assign reply_valid = reply_valid_r;

endmodule

//--- common/gdcr_pkg.sv
// package for the gate driver configuration and read-back block
// assumes one 10 MHz clock; the uart framer lives outside this block
package gdcr_pkg;

  // ----------------------------------------------------------------
  // configuration register layout
  // ----------------------------------------------------------------
  localparam int CFG_AMP_PD_BIT = 6;
  localparam int CFG_SLEEP_SEL_BIT = 5;
  localparam int CFG_UVLO_DIS_BIT = 3;
  localparam int CFG_SHORT_DIS_BIT = 2;
  localparam int CFG_OC_HI_BIT = 1;
  localparam int CFG_OC_LO_BIT = 0;
  localparam logic [7:0] CFG_RESET = 8'h00;
  // writable bits: 6,5,3,2,1,0; bits 7 and 4 read as zero
  localparam logic [7:0] CFG_WMASK = 8'h6f;

  // ----------------------------------------------------------------
  // timing configuration fields
  // ----------------------------------------------------------------
  localparam int DT_LSB = 2;
  localparam int DT_W = 3;
  localparam int BL_LSB = 0;
  localparam int BL_W = 2;
  localparam logic [2:0] DT_RESET = 3'h0;
  localparam logic [1:0] BL_RESET = 2'h0;
  localparam int DT_MAX_NS = 2000;
  localparam int DT_STEP_NS = 250;
  localparam int BL_MAX_NS = 4000;
  localparam int CLK_MHZ = 10;

  // ----------------------------------------------------------------
  // reply header bytes
  // ----------------------------------------------------------------
  localparam logic [7:0] TIM_ACK = 8'h48;
  localparam logic [7:0] TIM_NAK = 8'h08;
  localparam logic [7:0] REV_ACK = 8'h50;
  localparam logic [7:0] REV_NAK = 8'h10;

  // neutral revision code, value arbitrary
  localparam logic [3:0] HW_REV_DEFAULT = 4'h1;

  typedef enum logic [1:0] {
    GDCR_ACTIVE  = 2'b00,
    GDCR_STANDBY = 2'b01,
    GDCR_SLEEP   = 2'b10
  } gdcr_mode_t;

  typedef enum logic [1:0] {
    GDCR_Q_NONE = 2'b00,
    GDCR_Q_TIM  = 2'b01,
    GDCR_Q_REV  = 2'b10
  } gdcr_query_t;

  // two-byte reply carried to the framer
  typedef struct packed {
    logic [7:0] head;
    logic [7:0] body;
  } gdcr_reply_t;

  // settings handed to the analog and protection logic
  typedef struct packed {
    logic amp_standby_off;
    logic fet_gate_lockout_disable;
    logic fet_short_detect_disable;
    logic [1:0] oc_threshold;
    logic [2:0] dead_time_code;
    logic [1:0] blank_code;
  } gdcr_settings_t;

endpackage

//--- tb/gdcr_host_model.sv
// host side of the reply path: catches each two-byte reply
// assumes reply_valid is a one-cycle pulse on clock
`timescale 1ns/1ps
module gdcr_host_model
  import gdcr_pkg::*;
(
  input wire logic clock,
  input wire logic reply_valid,
  input wire gdcr_reply_t reply,
  output logic [7:0] got_head,
  output logic [7:0] got_body
);
  // head and body bytes are caught together on the same clock edge
  always @(posedge clock) begin
    if (reply_valid) begin
      got_head <= reply.head;
      got_body <= reply.body;
    end
  end
endmodule

//--- tb/gdcr_assertions.sv
// concurrent checks on the ports of gdcr_top
// assumes one clock and the synchronous active-low reset
`timescale 1ns/1ps
module gdcr_checker
  import gdcr_pkg::*;
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic drive_enable,
  input wire logic cfg_wr,
  input wire logic [7:0] cfg_wdata,
  input wire logic [1:0] query,
  input wire logic query_ok,
  input wire logic [7:0] cfg_rdata,
  input wire logic reply_valid,
  input wire gdcr_reply_t reply,
  input wire gdcr_mode_t mode,
  input wire logic amp_powered,
  input wire gdcr_settings_t settings
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  sequence s_tim_ask; query == 2'h1; endsequence
  sequence s_rev_ask; query == 2'h2; endsequence
  a_tim_head: assert property (s_tim_ask |=> reply_valid &&
    reply.head == ($past(query_ok) ? TIM_ACK : TIM_NAK)) else $error("timing head wrong");
  a_tim_body: assert property (s_tim_ask |=> reply.body ==
    {3'h0, $past(settings.dead_time_code), $past(settings.blank_code)})
    else $error("timing body wrong");
  a_no_spurious: assert property (query == 2'h0 || query == 2'h3 |=> !reply_valid)
    else $error("reply without query");
  a_rev_reply: assert property (s_rev_ask |=> reply_valid && reply.body[7:4] == 4'h0 &&
    reply.head == ($past(query_ok) ? REV_ACK : REV_NAK)) else $error("revision reply wrong");
  a_sleep_bit_kept: assert property (cfg_wr && mode != GDCR_STANDBY |=>
    cfg_rdata[5] == $past(cfg_rdata[5])) else $error("sleep bit changed");
  a_cfg_write: assert property (cfg_wr && mode == GDCR_STANDBY |=>
    cfg_rdata == ($past(cfg_wdata) & CFG_WMASK)) else $error("config write lost");
  a_enter_sleep: assert property ((!drive_enable && cfg_rdata[5])[*6] |->
    mode == GDCR_SLEEP) else $error("sleep not entered");
  a_enter_standby: assert property ((!drive_enable && !cfg_rdata[5])[*6] |->
    mode == GDCR_STANDBY) else $error("standby not entered");
  a_amp_power: assert property ($stable(mode) && $stable(cfg_rdata) |->
    amp_powered == !(mode == GDCR_STANDBY && cfg_rdata[6])) else $error("amp power wrong");
  a_cfg_map: assert property (settings[9:5] == {cfg_rdata[6], cfg_rdata[3:0]})
    else $error("settings differ from config");
endmodule
bind gdcr_top gdcr_checker i_gdcr_checker(
  .clock(clock),
  .rstn(rstn),
  .drive_enable(drive_enable),
  .cfg_wr(cfg_wr),
  .cfg_wdata(cfg_wdata),
  .query(query),
  .query_ok(query_ok),
  .cfg_rdata(cfg_rdata),
  .reply_valid(reply_valid),
  .reply(reply),
  .mode(mode),
  .amp_powered(amp_powered),
  .settings(settings)
);

//--- tb/gdcr_top_bench.sv
// self-checking bench for gdcr_top with a host model on the reply side
// assumes inputs change at the falling edge
`timescale 1ns/1ps
module gdcr_top_bench;
  import gdcr_pkg::*;
  logic clock = 0, rstn = 0, drive_enable = 0, cfg_wr = 0, tim_wr = 0, query_ok = 0;
  logic [7:0] cfg_wdata = 8'h00, tim_wdata = 8'h00, cfg_rdata, head, body, d;
  logic [1:0] query = 2'h0;
  logic reply_valid, amp_powered;
  gdcr_reply_t reply;
  gdcr_mode_t mode;
  gdcr_settings_t settings;
  int errors = 0, checked = 0;
  always #50 clock = ~clock;
  gdcr_top i_gdcr_top(.clock(clock), .rstn(rstn), .drive_enable(drive_enable),
    .cfg_wr(cfg_wr), .cfg_wdata(cfg_wdata), .tim_wr(tim_wr), .tim_wdata(tim_wdata),
    .query(query), .query_ok(query_ok), .cfg_rdata(cfg_rdata), .reply_valid(reply_valid),
    .reply(reply), .mode(mode), .amp_powered(amp_powered), .settings(settings));
  gdcr_host_model i_gdcr_host_model(.clock(clock), .reply_valid(reply_valid),
    .reply(reply), .got_head(head), .got_body(body));
  task automatic check(string what, logic [7:0] exp, logic [7:0] got);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic stop_test;
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  function automatic logic [7:0] tim_body(logic [7:0] w);
    return {3'h0, w[4:2], w[1:0]};
  endfunction
  function automatic logic [7:0] cfg_map(logic [7:0] w);
    return {3'h0, w[6], w[3:0]};
  endfunction
  task automatic cyc(int k);
    repeat (k) @(negedge clock);
  endtask
  task automatic wr_cfg(logic [7:0] v);
    cfg_wdata = v;
    cfg_wr = 1;
    cyc(1);
    cfg_wr = 0;
  endtask
  task automatic ask(logic [1:0] q, logic ok, logic [7:0] h, logic [7:0] b);
    query = q;
    query_ok = ok;
    cyc(1);
    query = 2'h0;
    check("valid", 8'h01, {7'h0, reply_valid});
    cyc(1);
    check("valid low", 8'h00, {7'h0, reply_valid});
    check("head", h, head);
    check("body", b, body);
  endtask
  initial begin
    void'($urandom(23));
    cyc(3);
    rstn = 1;
    check("cfg reset", CFG_RESET, cfg_rdata);
    check("mode reset", {6'h0, GDCR_STANDBY}, {6'h0, mode});
    check("amp reset", 8'h01, {7'h0, amp_powered});
    for (int i = 0; i < 16; i++) begin
      d = (i < 8) ? {3'h0, i[2:0], i[1:0]} : 8'($urandom);
      tim_wdata = d;
      tim_wr = 1;
      cyc(1);
      tim_wr = 0;
      check("timing settings", {3'h0, d[4:0]}, {3'h0, settings[4:0]});
      ask(2'h1, i[0], i[0] ? TIM_ACK : TIM_NAK, tim_body(d));
      ask(2'h2, i[1], i[1] ? REV_ACK : REV_NAK, {4'h0, HW_REV_DEFAULT});
      // sleep bit kept clear here so the device stays in standby
      wr_cfg(8'($urandom) & 8'hdf);
      check("cfg", cfg_wdata & CFG_WMASK, cfg_rdata);
      check("cfg map", cfg_map(cfg_wdata), {3'h0, settings[9:5]});
    end
    // code 3 is no query; it also spaces the two register writes apart
    query = 2'h3;
    cyc(1);
    query = 2'h0;
    check("valid on code 3", 8'h00, {7'h0, reply_valid});
    wr_cfg(8'h00);
    drive_enable = 1;
    cyc(8);
    check("mode active", {6'h0, GDCR_ACTIVE}, {6'h0, mode});
    wr_cfg(8'h20);
    check("sleep bit", 8'h00, cfg_rdata);
    drive_enable = 0;
    cyc(8);
    check("mode standby", {6'h0, GDCR_STANDBY}, {6'h0, mode});
    wr_cfg(8'h40);
    cyc(1);
    check("amp", 8'h00, {7'h0, amp_powered});
    wr_cfg(8'h60);
    cyc(8);
    check("mode sleep", {6'h0, GDCR_SLEEP}, {6'h0, mode});
    check("amp in sleep", 8'h01, {7'h0, amp_powered});
    // second reset from sleep: everything must fall back to its reset value
    rstn = 0;
    cyc(1);
    rstn = 1;
    check("mode after reset", {6'h0, GDCR_STANDBY}, {6'h0, mode});
    check("cfg after reset", CFG_RESET, cfg_rdata);
    check("amp after reset", 8'h01, {7'h0, amp_powered});
    check("reply after reset", 8'h00, reply.head);
    stop_test();
  end
  initial begin
    cyc(400);
    errors++;
    stop_test();
  end
endmodule
